// ### status_word_regs.svh
// field positions and reset values of the primary-side status word
`ifndef STATUS_WORD_REGS_SVH
`define STATUS_WORD_REGS_SVH

`define STATUS_WORD_WIDTH 16
`define STATUS_WORD_RESET 16'h0000
`define BIT_RESERVED_TOP 15
`define BIT_PRIMARY_READY 14
`define BIT_PRIMARY_UNDERVOLTAGE 13
`define BIT_PRIMARY_OVERVOLTAGE 12
`define BIT_SHOOT_THROUGH 11
`define BIT_REGULATOR_CURRENT_LIMIT 10
`define BIT_SPI_FAULT 9
`define BIT_INTERNAL_RAIL_FAULT 8
`define FRAME_CLOCK_MULTIPLE 16
`define FRAME_COUNT_WIDTH 4

`endif

// ### status_word_pkg.sv
// types shared by the status word block
package status_word_pkg;
	typedef enum logic [1:0] {
		clear_idle,
		clear_armed
	} clear_state_t;
	typedef logic [15:0] status_word_t;
endpackage

// ### sticky_flag.sv
// a bank of latched fault flags: set wins over clear
`timescale 1ns/10ps
module sticky_flag
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clear_in,
	output logic [WIDTH-1:0] flag_out
);
	logic [WIDTH-1:0] flag_reg;
	logic [WIDTH-1:0] flag_next;

	// a fault arriving in the clearing cycle must not be lost
	assign flag_next = set_in | (flag_reg & ~clear_in);
	assign flag_out = flag_reg;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			flag_reg <= '0;
		else
			flag_reg <= flag_next;
	end
endmodule // sticky_flag

// ### primary_status_word.sv
// primary-side upper status word with latched faults and frame checking
`timescale 1ns/10ps
`include "status_word_regs.svh"

// What this block does
// RQ1: bit 14 shows primary side ready
// RQ2: bit 13 latches primary undervoltage fault
// RQ3: bit 12 latches primary overvoltage fault
// RQ4: bit 11 latches both inputs high
// RQ5: bit 10 latches regulator current limit
// RQ6: bit 9 set on bad clock count
// RQ7: bit 9 set on check value mismatch
// RQ8: bit 9 clears after valid command, read
// RQ9: bit 8 latches internal rail faults
// RQ10: bit 15 always reads zero
// RQ11: host writes never alter the word
module primary_status_word
#(
	parameter int FRAME_MULTIPLE = `FRAME_CLOCK_MULTIPLE
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic primary_ready,
	input wire logic primary_supply_under,
	input wire logic primary_supply_over,
	input wire logic input_noninverting,
	input wire logic input_inverting,
	input wire logic regulator_current_limit,
	input wire logic internal_rail_fault,
	input wire logic chip_select_low,
	input wire logic serial_clock_rise,
	input wire logic frame_check_error,
	input wire logic frame_valid,
	input wire logic status_read,
	input wire logic status_write,
	input wire logic [15:0] status_write_data,
	output status_word_pkg::status_word_t status_word
);
	import status_word_pkg::*;

	// ****************************************
	// local constants
	// ****************************************
	// a frame must carry a whole number of words of this many clock edges
	localparam int COUNT_W = $clog2(FRAME_MULTIPLE);
	localparam logic [COUNT_W-1:0] COUNT_LAST = COUNT_W'(FRAME_MULTIPLE - 1);

	// five level-type faults share one flag bank
	localparam int FLAG_COUNT = 5;

	// ****************************************
	// frame clock counting
	// ****************************************
	logic cs_low_reg;
	logic [COUNT_W-1:0] clk_count_reg;
	logic [COUNT_W-1:0] clk_count_next;
	logic [COUNT_W-1:0] clk_count_step;
	logic count_at_last;

	// modulo count, so the multiple need not be a power of two (it must be 2 or more)
	assign count_at_last = (clk_count_reg == COUNT_LAST);
	assign clk_count_step = count_at_last ? '0 : clk_count_reg + COUNT_W'(1);
	// edges outside the frame are dropped, and each frame starts from zero
	assign clk_count_next = !chip_select_low ? '0
		: (serial_clock_rise ? clk_count_step : clk_count_reg);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cs_low_reg <= 1'b0;
			clk_count_reg <= '0;
		end
		else
		begin
			cs_low_reg <= chip_select_low;
			clk_count_reg <= clk_count_next;
		end
	end

	// ****************************************
	// frame end check
	// ****************************************
	logic frame_end;
	logic frame_short;
	logic spi_fault_set;

	// select released this cycle; the count still holds the whole frame
	assign frame_end = cs_low_reg & ~chip_select_low;
	assign frame_short = frame_end & (clk_count_reg != '0); // see RQ6
	assign spi_fault_set = frame_short | frame_check_error; // see RQ7

	// ****************************************
	// fault clearing sequence
	// ****************************************
	clear_state_t clear_reg;
	clear_state_t clear_next;
	logic spi_fault_clear;

	// clear only once a valid command has been seen, then the word is read
	always_comb
	begin
		clear_next = clear_reg;
		case (clear_reg)
			clear_idle:
			begin
				if (frame_valid)
					clear_next = clear_armed;
			end
			clear_armed:
			begin
				if (status_read)
					clear_next = clear_idle;
			end
			default: clear_next = clear_idle;
		endcase
	end
	assign spi_fault_clear = (clear_reg == clear_armed) & status_read; // see RQ8

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			clear_reg <= clear_idle;
		else
			clear_reg <= clear_next;
	end

	// ****************************************
	// fault causes
	// ****************************************
	logic shoot_through_now;
	logic [FLAG_COUNT-1:0] flag_set;
	logic [FLAG_COUNT-1:0] flag_clr;

	assign shoot_through_now = input_noninverting & input_inverting;
	assign flag_set[0] = primary_supply_under; // see RQ2
	assign flag_set[1] = primary_supply_over; // see RQ3
	assign flag_set[2] = shoot_through_now; // see RQ4
	assign flag_set[3] = regulator_current_limit; // see RQ5
	assign flag_set[4] = internal_rail_fault; // see RQ9
	// level faults clear on a read only once their cause has gone
	assign flag_clr[0] = status_read & ~primary_supply_under;
	assign flag_clr[1] = status_read & ~primary_supply_over;
	// an overlap still present in the read cycle sets it again, as set wins
	assign flag_clr[2] = status_read;
	assign flag_clr[3] = status_read & ~regulator_current_limit;
	assign flag_clr[4] = status_read & ~internal_rail_fault;

	// ****************************************
	// latched fault flags
	// ****************************************
	logic [FLAG_COUNT-1:0] flag_val;
	logic spi_fault_flag;

	sticky_flag #(
		.WIDTH(FLAG_COUNT)
	) u_level_flags (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.set_in(flag_set),
		.clear_in(flag_clr),
		.flag_out(flag_val)
	);

	sticky_flag #(
		.WIDTH(1)
	) u_spi_flag (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.set_in(spi_fault_set),
		.clear_in(spi_fault_clear),
		.flag_out(spi_fault_flag)
	);

	// ****************************************
	// ready copy
	// ****************************************
	logic ready_reg;

	// registered so the ready bit moves in step with the latched faults
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			ready_reg <= 1'b0;
		else
			ready_reg <= primary_ready; // see RQ1
	end

	// ****************************************
	// named fields
	// ****************************************
	logic primary_ready_flag;
	logic primary_undervoltage_flag;
	logic primary_overvoltage_flag;
	logic shoot_through_flag;
	logic regulator_current_limit_flag;
	logic internal_rail_fault_flag;

	assign primary_ready_flag = ready_reg;
	assign primary_undervoltage_flag = flag_val[0];
	assign primary_overvoltage_flag = flag_val[1];
	assign shoot_through_flag = flag_val[2];
	assign regulator_current_limit_flag = flag_val[3];
	assign internal_rail_fault_flag = flag_val[4];

	// ****************************************
	// word assembly
	// ****************************************
	// the write port reaches nothing here, so the word cannot be altered from outside
	always_comb
	begin
		status_word = `STATUS_WORD_RESET; // see RQ11
		status_word[`BIT_RESERVED_TOP] = 1'b0; // see RQ10
		status_word[`BIT_PRIMARY_READY] = primary_ready_flag;
		status_word[`BIT_PRIMARY_UNDERVOLTAGE] = primary_undervoltage_flag;
		status_word[`BIT_PRIMARY_OVERVOLTAGE] = primary_overvoltage_flag;
		status_word[`BIT_SHOOT_THROUGH] = shoot_through_flag;
		status_word[`BIT_REGULATOR_CURRENT_LIMIT] = regulator_current_limit_flag;
		status_word[`BIT_SPI_FAULT] = spi_fault_flag;
		status_word[`BIT_INTERNAL_RAIL_FAULT] = internal_rail_fault_flag;
	end
endmodule // primary_status_word

// ### status_host_model.sv
// host side model that frames serial clock edges under chip select
`timescale 1ns/10ps
module status_host_model
(
	input wire logic clk_sys,
	output logic chip_select_low,
	output logic serial_clock_rise
);
	initial chip_select_low = 1'b0;
	initial serial_clock_rise = 1'b0;
	// clock pulses only inside the frame, never between frames
	task frame(input int n);
		@(negedge clk_sys) chip_select_low = 1'b1;
		repeat (n)
		begin
			@(negedge clk_sys) serial_clock_rise = 1'b1;
			@(negedge clk_sys) serial_clock_rise = 1'b0;
		end
		@(negedge clk_sys) chip_select_low = 1'b0;
	endtask
endmodule // status_host_model

// ### primary_status_word_props.sv
// concurrent checks on the status word ports
`timescale 1ns/10ps
module primary_status_word_props
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic primary_ready,
	input wire logic primary_supply_under,
	input wire logic primary_supply_over,
	input wire logic input_noninverting,
	input wire logic input_inverting,
	input wire logic regulator_current_limit,
	input wire logic internal_rail_fault,
	input wire logic status_read,
	input wire logic status_write,
	input wire logic frame_check_error,
	input wire logic [15:0] status_word
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_rdy; primary_ready |=> status_word[14]; endproperty
	a_rdy: assert property (p_rdy) else $error("ready");
	property p_uv; primary_supply_under |=> status_word[13]; endproperty
	a_uv: assert property (p_uv) else $error("uv");
	property p_ov; primary_supply_over |=> status_word[12]; endproperty
	a_ov: assert property (p_ov) else $error("ov");
	property p_st; input_noninverting && input_inverting |=> status_word[11]; endproperty
	a_st: assert property (p_st) else $error("st");
	property p_il; regulator_current_limit |=> status_word[10]; endproperty
	a_il: assert property (p_il) else $error("il");
	property p_rl; internal_rail_fault |=> status_word[8]; endproperty
	a_rl: assert property (p_rl) else $error("rail");
	property p_rs; status_word[15] == 1'b0; endproperty
	a_rs: assert property (p_rs) else $error("top");
	// latched bits may only fall on a read, so a lone write drops none
	property p_ro; status_write && !status_read |=>
		(~status_word & $past(status_word) & 16'hBF00) == 16'h0000; endproperty
	a_ro: assert property (p_ro) else $error("write");
	property p_ce; frame_check_error |=> status_word[9]; endproperty
	a_ce: assert property (p_ce) else $error("check");
	// the serial fault may only fall on a read
	property p_sh; status_word[9] && !status_read |=> status_word[9]; endproperty
	a_sh: assert property (p_sh) else $error("spi hold");
endmodule // primary_status_word_props

// ### primary_status_word_tb.sv
// self-checking testbench for the primary-side status word
`timescale 1ns/10ps
module primary_status_word_tb;
	import status_word_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [6:0] f = 7'h00;
	logic [3:0] s = 4'h0;
	logic [15:0] status_write_data = 16'hFFFF;
	wire primary_ready, primary_supply_under, primary_supply_over, input_noninverting;
	wire input_inverting, regulator_current_limit, internal_rail_fault, status_read;
	wire status_write, frame_valid, frame_check_error, chip_select_low, serial_clock_rise;
	status_word_t status_word;
	int bad_count = 0;
	int n_compared = 0;
	logic [6:0] fv [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h0C, 7'h02, 7'h01};
	logic [15:0] ev [7] = '{16'h4000, 16'h2000, 16'h1000, 16'h0000, 16'h0800, 16'h0400, 16'h0100};
	assign {primary_ready, primary_supply_under, primary_supply_over, input_noninverting,
		input_inverting, regulator_current_limit, internal_rail_fault} = f;
	assign {status_read, status_write, frame_valid, frame_check_error} = s;
	always #12.5 clk_sys = ~clk_sys;
	primary_status_word i_primary_status_word (.*);
	status_host_model i_status_host_model (.*);
	task chk(input logic [15:0] e);
		n_compared++;
		if (status_word !== e)
		begin
			$display("[ERR] %0t %h %h", $time, status_word, e);
			bad_count++;
		end
	endtask
	task step(input logic [3:0] p);
		@(negedge clk_sys) s = p;
		@(negedge clk_sys) s = 4'h0;
	endtask
	task complete_run;
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge clk_sys);
		chk(16'h0000);
		nrst = 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			@(negedge clk_sys) f = fv[i];
			repeat (2) @(negedge clk_sys);
			chk(ev[i]);
			f = 7'h00;
			step(4'h4);
			chk(ev[i] & 16'hBF00);
			step(4'h8);
			chk(16'h0000);
		end
		i_status_host_model.frame(15);
		@(negedge clk_sys);
		chk(16'h0200);
		step(4'hA);
		chk(16'h0200);
		step(4'h8);
		chk(16'h0000);
		i_status_host_model.frame(32);
		@(negedge clk_sys);
		chk(16'h0000);
		step(4'h1);
		chk(16'h0200);
		step(4'h8);
		chk(16'h0200);
		step(4'h2);
		step(4'h8);
		chk(16'h0000);
		complete_run;
	end
endmodule // primary_status_word_tb
bind primary_status_word primary_status_word_props i_primary_status_word_props (.*);
